/* File: core/port_cmd_pkg.sv */
/*
 File: constants shared by the port command decoder and its capability register.
 Assumes: a byte-wide register port supplied by the device's serial front end.
*/
package port_cmd_pkg;

	// Register offsets
	localparam logic [7:0] port_command_off        = 8'h23;
	localparam logic [7:0] port_capability_byte0_off = 8'h24;

	// Reset values
	localparam logic [7:0] port_command_rst        = 8'h00;
	localparam logic [7:0] port_capability_byte0_rst = 8'h98;

	// Capability byte fields
	localparam int cap_roles_msb         = 7;
	localparam int cap_roles_lsb         = 5;
	localparam int cap_debug_packets_bit = 4;
	localparam int cap_vconn_bit         = 3;
	localparam int cap_sink_path_bit     = 2;
	localparam int cap_src_high_bit      = 1;
	localparam int cap_src_bus_bit       = 0;
	localparam logic [2:0] roles_dual_only = 3'h4;

	// Termination field codes
	localparam logic [1:0] term_pull_up   = 2'h1;
	localparam logic [1:0] term_pull_down = 2'h2;

	// Command codes
	localparam logic [7:0] cmd_wake                = 8'h11;
	localparam logic [7:0] cmd_detect_off          = 8'h22;
	localparam logic [7:0] cmd_detect_on           = 8'h33;
	localparam logic [7:0] cmd_sink_off            = 8'h44;
	localparam logic [7:0] cmd_sink_on             = 8'h55;
	localparam logic [7:0] cmd_source_off          = 8'h66;
	localparam logic [7:0] cmd_source_default_volt = 8'h77;
	localparam logic [7:0] cmd_source_high_volt    = 8'h88;
	localparam logic [7:0] cmd_search_attach       = 8'h99;
	localparam logic [7:0] cmd_rx_final_packet     = 8'hAA;
	localparam logic [7:0] cmd_reserved_c          = 8'hCC;
	localparam logic [7:0] cmd_reserved_d          = 8'hDD;
	localparam logic [7:0] cmd_reserved_e          = 8'hEE;
	localparam logic [7:0] cmd_bus_idle            = 8'hFF;

	typedef enum logic [3:0] {
		op_none,
		op_src_default,
		op_src_high,
		op_src_off,
		op_sink_on,
		op_sink_off,
		op_detect_on,
		op_detect_off,
		op_search,
		op_rx_final
	} cmd_op_t;

endpackage

/* File: core/cmd_classifier.sv */
/*
 File: combinational classifier mapping a command byte to an operation.
 Assumes: the caller registers the result; codes outside the table map to no operation.
*/
`timescale 1ns/1ps
module cmd_classifier
(
	// Command byte
	input  wire logic [7:0]               code,
	// Decoded operation
	output port_cmd_pkg::cmd_op_t         op
);

	always_comb
	begin
		case (code)
			port_cmd_pkg::cmd_source_default_volt: op = port_cmd_pkg::op_src_default;
			port_cmd_pkg::cmd_source_high_volt:    op = port_cmd_pkg::op_src_high;
			port_cmd_pkg::cmd_source_off:          op = port_cmd_pkg::op_src_off;
			port_cmd_pkg::cmd_sink_on:             op = port_cmd_pkg::op_sink_on;
			port_cmd_pkg::cmd_sink_off:            op = port_cmd_pkg::op_sink_off;
			port_cmd_pkg::cmd_detect_on:           op = port_cmd_pkg::op_detect_on;
			port_cmd_pkg::cmd_detect_off:          op = port_cmd_pkg::op_detect_off;
			port_cmd_pkg::cmd_search_attach:       op = port_cmd_pkg::op_search;
			port_cmd_pkg::cmd_rx_final_packet:     op = port_cmd_pkg::op_rx_final;
			// Reserved, wake, idle and unknown codes are accepted silently
			default:                               op = port_cmd_pkg::op_none;
		endcase
	end

endmodule

/* File: core/port_command_decoder.sv */
/*
 File: command register decoder and read-only capability byte of a port controller.
 Assumes: a byte register port (address, write strobe, data) from the serial
 front end, synchronous to sys_clk; role configuration, attach and receive
 status come from neighbouring blocks of the same clock domain.
*/
// Summary of operation
// (R1) 77h sources bus if source capability set
// (R2) 88h sets high flag if capable
// (R3) 99h toggles only when dual-role bit set
// (R4) Both 01b: pull-up first; 10b: pull-down
// (R5) Mismatched termination fields: no toggling
// (R6) Manager reissues search for unchanged roles
// (R7) Lost sink returns to unattached source
// (R8) AAh clears receive-detect after next GoodCRC
// (R9) CCh, DDh, EEh reserved, no action
// (R10) FFh idle accepted, no action
// (R11) Roles field 7:5 reads 100
// (R12) Bit 4 reads 1, debug packets
// (R13) Bit 3 reads 1, VCONN switch
// (R14) Bit 2 reads 0, no sink path
// (R15) Bit 1 reads 0, no high source
// (R16) Bit 0 reads 0, no source path
// (R17) Capability byte read-only, resets 98h
// (R18) Unknown command codes change nothing
`timescale 1ns/1ps
module port_command_decoder
#(
	parameter logic [7:0] cap_value = port_cmd_pkg::port_capability_byte0_rst
)
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata_q,
	// Role configuration from role_config_reg
	input  wire logic       role_dual,
	input  wire logic [1:0] role_cc1,
	input  wire logic [1:0] role_cc2,
	// Attach events
	input  wire logic       src_attach_seen,
	input  wire logic       sink_gone,
	// Receive path events
	input  wire logic       goodcrc_sent,
	// Power status and control
	output logic            flag_sourcing_bus_q,
	output logic            flag_sourcing_high_q,
	output logic            flag_sinking_q,
	output logic            bus_detect_en_q,
	// Connection search
	output logic            toggle_active_q,
	output logic            pull_up_q,
	output logic            pull_down_q,
	output logic            unattached_src_q,
	// Receive control
	output logic            rx_final_armed_q,
	output logic            rx_detect_clr_q
);

	typedef enum logic [1:0] {
		st_idle,
		st_toggling,
		st_src_candidate
	} link_st_t;

	port_cmd_pkg::cmd_op_t op;
	link_st_t              link_q;
	logic      [7:0]       command_q;
	logic                  cmd_wr;
	logic                  term_up;
	logic                  term_down;

	// Capability byte is a constant: no write path exists
	localparam logic [7:0] cap_byte = cap_value;

	function automatic logic both_equal(input logic [1:0] a, input logic [1:0] b,
		input logic [1:0] code);
		both_equal = (a == code) && (b == code);
	endfunction

	assign cmd_wr    = reg_wr && (reg_addr == port_cmd_pkg::port_command_off);
	assign term_up   = both_equal(role_cc1, role_cc2, port_cmd_pkg::term_pull_up);
	assign term_down = both_equal(role_cc1, role_cc2, port_cmd_pkg::term_pull_down);

	cmd_classifier cmd_classifier_i
	(
		.code (reg_wdata),
		.op   (op)
	);

	// Command register keeps the last byte written
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			command_q <= port_cmd_pkg::port_command_rst;
		else if (cmd_wr)
			command_q <= reg_wdata;
	end

	// Read mux; writes to the capability byte have no effect
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_q <= 8'h00;
		else if (reg_addr == port_cmd_pkg::port_capability_byte0_off)
			reg_rdata_q <= cap_byte; // R11 R12 R13 R14 R15 R16 R17
		else if (reg_addr == port_cmd_pkg::port_command_off)
			reg_rdata_q <= command_q;
		else
			reg_rdata_q <= 8'h00;
	end

	// Sourcing flags, gated by capability bits
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flag_sourcing_bus_q  <= 1'b0;
			flag_sourcing_high_q <= 1'b0;
		end
		else if (cmd_wr)
		begin
			case (op)
				port_cmd_pkg::op_src_default:
					if (cap_byte[port_cmd_pkg::cap_src_bus_bit])
						flag_sourcing_bus_q <= 1'b1; // R1
				port_cmd_pkg::op_src_high:
					if (cap_byte[port_cmd_pkg::cap_src_high_bit])
						flag_sourcing_high_q <= 1'b1; // R2
				port_cmd_pkg::op_src_off:
				begin
					flag_sourcing_bus_q  <= 1'b0;
					flag_sourcing_high_q <= 1'b0;
				end
				default:
				begin
					flag_sourcing_bus_q  <= flag_sourcing_bus_q;
					flag_sourcing_high_q <= flag_sourcing_high_q;
				end
			endcase
		end
	end

	// Sink flag and bus presence detection
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flag_sinking_q  <= 1'b0;
			bus_detect_en_q <= 1'b0;
		end
		else if (cmd_wr)
		begin
			case (op)
				port_cmd_pkg::op_src_default:
					if (cap_byte[port_cmd_pkg::cap_src_bus_bit])
						bus_detect_en_q <= 1'b1; // R1
				port_cmd_pkg::op_sink_on:
					if (cap_byte[port_cmd_pkg::cap_sink_path_bit])
					begin
						flag_sinking_q  <= 1'b1;
						bus_detect_en_q <= 1'b1;
					end
				port_cmd_pkg::op_sink_off:   flag_sinking_q  <= 1'b0;
				port_cmd_pkg::op_detect_on:  bus_detect_en_q <= 1'b1;
				port_cmd_pkg::op_detect_off: bus_detect_en_q <= 1'b0;
				default:                     bus_detect_en_q <= bus_detect_en_q; // R9 R10 R18
			endcase
		end
	end

	// Connection search state; nothing restarts it except the search command (R6)
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			link_q      <= st_idle;
			pull_up_q   <= 1'b0;
			pull_down_q <= 1'b0;
		end
		else if (cmd_wr && op == port_cmd_pkg::op_search)
		begin
			if (role_dual && (term_up || term_down)) // R3 R5
			begin
				link_q      <= st_toggling;
				pull_up_q   <= term_up; // R4
				pull_down_q <= term_down; // R4
			end
		end
		else
		begin
			case (link_q)
				st_toggling:
					if (src_attach_seen && pull_up_q)
						link_q <= st_src_candidate;
					else if (src_attach_seen || sink_gone)
					begin
						// Swap termination on a sink loss or an attach, unless an attach is seen while pulled up
						pull_up_q   <= pull_down_q;
						pull_down_q <= pull_up_q;
					end
				st_src_candidate:
					if (sink_gone)
					begin
						// Role configuration is untouched here
						link_q      <= st_idle; // R7
						pull_up_q   <= 1'b1; // R7
						pull_down_q <= 1'b0;
					end
				st_idle:
					link_q <= st_idle;
				default:
					link_q <= st_idle;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			toggle_active_q  <= 1'b0;
			unattached_src_q <= 1'b0;
		end
		else
		begin
			toggle_active_q  <= (link_q == st_toggling);
			unattached_src_q <= (link_q == st_idle) && pull_up_q;
		end
	end

	// Receive shutdown after the next acknowledgement
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_final_armed_q <= 1'b0;
			rx_detect_clr_q  <= 1'b0;
		end
		else
		begin
			rx_detect_clr_q <= rx_final_armed_q && goodcrc_sent; // R8
			// A new arm in the same cycle as the acknowledgement wins
			if (cmd_wr && op == port_cmd_pkg::op_rx_final)
				rx_final_armed_q <= 1'b1; // R8
			else if (goodcrc_sent)
				rx_final_armed_q <= 1'b0;
		end
	end

	// Checks
	property p_src_default;
		@(posedge sys_clk) disable iff (!rst_n)
		(cmd_wr && reg_wdata == port_cmd_pkg::cmd_source_default_volt && !flag_sourcing_bus_q)
			|=> (flag_sourcing_bus_q == cap_byte[port_cmd_pkg::cap_src_bus_bit]);
	endproperty
	a_src_default: assert property (p_src_default) else $error("source flag mismatch"); // R1

	property p_src_high;
		@(posedge sys_clk) disable iff (!rst_n)
		(cmd_wr && reg_wdata == port_cmd_pkg::cmd_source_high_volt)
			|=> (flag_sourcing_high_q == ($past(flag_sourcing_high_q)
			|| cap_byte[port_cmd_pkg::cap_src_high_bit]));
	endproperty
	a_src_high: assert property (p_src_high) else $error("high flag mismatch"); // R2

	property p_no_dual;
		@(posedge sys_clk) disable iff (!rst_n)
		(cmd_wr && reg_wdata == port_cmd_pkg::cmd_search_attach && !role_dual
			&& link_q == st_idle) |=> ##1 !toggle_active_q;
	endproperty
	a_no_dual: assert property (p_no_dual) else $error("toggle without dual role"); // R3

	property p_start_up;
		@(posedge sys_clk) disable iff (!rst_n)
		(cmd_wr && reg_wdata == port_cmd_pkg::cmd_search_attach && role_dual && term_up)
			|=> pull_up_q && !pull_down_q ##1 toggle_active_q;
	endproperty
	a_start_up: assert property (p_start_up) else $error("pull-up not first"); // R4

	property p_bad_term;
		@(posedge sys_clk) disable iff (!rst_n)
		(cmd_wr && reg_wdata == port_cmd_pkg::cmd_search_attach && link_q == st_idle
			&& !term_up && !term_down) |=> link_q == st_idle;
	endproperty
	a_bad_term: assert property (p_bad_term) else $error("toggle on bad fields"); // R5

	property p_lost_sink;
		@(posedge sys_clk) disable iff (!rst_n)
		(link_q == st_src_candidate && sink_gone && !cmd_wr) |=> ##1 unattached_src_q;
	endproperty
	a_lost_sink: assert property (p_lost_sink) else $error("no return to unattached"); // R7

	property p_rx_final;
		@(posedge sys_clk) disable iff (!rst_n)
		(rx_final_armed_q && goodcrc_sent) |=> rx_detect_clr_q;
	endproperty
	a_rx_final: assert property (p_rx_final) else $error("receive clear missed"); // R8

	property p_reserved;
		@(posedge sys_clk) disable iff (!rst_n)
		(cmd_wr && op == port_cmd_pkg::op_none)
			|=> $stable(flag_sourcing_bus_q) && $stable(bus_detect_en_q)
			&& $stable(flag_sinking_q);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code acted"); // R9

	property p_cap;
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_addr == port_cmd_pkg::port_capability_byte0_off)
			|=> reg_rdata_q == port_cmd_pkg::port_capability_byte0_rst;
	endproperty
	a_cap: assert property (p_cap) else $error("capability byte wrong"); // R17

	property p_cap_roles;
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_addr == port_cmd_pkg::port_capability_byte0_off)
			|=> reg_rdata_q[port_cmd_pkg::cap_roles_msb:port_cmd_pkg::cap_roles_lsb]
			== port_cmd_pkg::roles_dual_only;
	endproperty
	a_cap_roles: assert property (p_cap_roles) else $error("roles field wrong"); // R11

	property p_cap_debug;
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_addr == port_cmd_pkg::port_capability_byte0_off)
			|=> reg_rdata_q[port_cmd_pkg::cap_debug_packets_bit] == 1'b1;
	endproperty
	a_cap_debug: assert property (p_cap_debug) else $error("debug packet bit wrong"); // R12

	property p_cap_vconn;
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_addr == port_cmd_pkg::port_capability_byte0_off)
			|=> reg_rdata_q[port_cmd_pkg::cap_vconn_bit] == 1'b1;
	endproperty
	a_cap_vconn: assert property (p_cap_vconn) else $error("cable power bit wrong"); // R13

	property p_cap_sink;
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_addr == port_cmd_pkg::port_capability_byte0_off)
			|=> reg_rdata_q[port_cmd_pkg::cap_sink_path_bit] == 1'b0;
	endproperty
	a_cap_sink: assert property (p_cap_sink) else $error("sink path bit wrong"); // R14

	property p_cap_high;
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_addr == port_cmd_pkg::port_capability_byte0_off)
			|=> reg_rdata_q[port_cmd_pkg::cap_src_high_bit] == 1'b0;
	endproperty
	a_cap_high: assert property (p_cap_high) else $error("high source bit wrong"); // R15

	property p_cap_bus;
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_addr == port_cmd_pkg::port_capability_byte0_off)
			|=> reg_rdata_q[port_cmd_pkg::cap_src_bus_bit] == 1'b0;
	endproperty
	a_cap_bus: assert property (p_cap_bus) else $error("source path bit wrong"); // R16

endmodule

/* File: bench/manager_model.sv */
/*
 Port manager model: turns bench requests into one-cycle register writes at the requested address.
 Assumes: requests change at the falling clock edge and last one cycle each.
*/
`timescale 1ns/1ps
module manager_model
(
	// Clock
	input  wire logic       sys_clk,
	// Requests from the bench
	input  wire logic       req,
	input  wire logic [7:0] req_addr,
	input  wire logic [7:0] req_data,
	// Register port toward the device
	output logic            reg_wr,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata
);
	logic [7:0] last_data = 8'h00;

	always @(posedge sys_clk)
	begin
		if (req)
			last_data <= req_data;
	end

	// Idle data shows the inverse byte, so a stale value never passes for a write
	assign reg_wr    = req;
	assign reg_addr  = req_addr;
	assign reg_wdata = req ? req_data : ~last_data;
endmodule

/* File: bench/port_command_decoder_bench.sv */
/*
 Self-checking bench for the port command decoder.
 Assumes: the manager model drives the register port; events come from the bench.
*/
`timescale 1ns/1ps
module port_command_decoder_bench;
	logic       sys_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       req = 1'b0;
	logic [7:0] req_addr = 8'h00;
	logic [7:0] req_data = 8'h00;
	logic       role_dual = 1'b0;
	logic [1:0] role_cc1 = 2'h0;
	logic [1:0] role_cc2 = 2'h0;
	logic       src_attach_seen = 1'b0;
	logic       sink_gone = 1'b0;
	logic       goodcrc_sent = 1'b0;
	logic       reg_wr;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata_q;
	logic [9:0] outs;
	logic [9:0] snap;
	int         n_mismatch = 0;
	int         comparisons = 0;
	logic [7:0] quiet_codes [9] = '{8'h77, 8'h88, 8'h55, 8'hCC, 8'hDD, 8'hEE, 8'hFF,
		8'h11, 8'h5A};

	always #2.5 sys_clk = ~sys_clk;

	manager_model manager_model_i
	(
		.sys_clk   (sys_clk),
		.req       (req),
		.req_addr  (req_addr),
		.req_data  (req_data),
		.reg_wr    (reg_wr),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata)
	);

	port_command_decoder port_command_decoder_i
	(
		.sys_clk              (sys_clk),
		.rst_n                (rst_n),
		.reg_addr             (reg_addr),
		.reg_wr               (reg_wr),
		.reg_wdata            (reg_wdata),
		.reg_rdata_q          (reg_rdata_q),
		.role_dual            (role_dual),
		.role_cc1             (role_cc1),
		.role_cc2             (role_cc2),
		.src_attach_seen      (src_attach_seen),
		.sink_gone            (sink_gone),
		.goodcrc_sent         (goodcrc_sent),
		.flag_sourcing_bus_q  (outs[9]),
		.flag_sourcing_high_q (outs[8]),
		.flag_sinking_q       (outs[7]),
		.bus_detect_en_q      (outs[6]),
		.toggle_active_q      (outs[5]),
		.pull_up_q            (outs[4]),
		.pull_down_q          (outs[3]),
		.unattached_src_q     (outs[2]),
		.rx_final_armed_q     (outs[1]),
		.rx_detect_clr_q      (outs[0])
	);

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic do_reset();
		@(negedge sys_clk);
		rst_n = 1'b0;
		cyc(3);
		rst_n = 1'b1;
	endtask

	// One write per call; the idle cycle after it keeps strobes from merging
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		req = 1'b1;
		req_addr = a;
		req_data = d;
		@(negedge sys_clk);
		req = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(negedge sys_clk);
		req_addr = a;
		@(negedge sys_clk);
		chk(nm, {2'b00, e}, {2'b00, reg_rdata_q});
	endtask

	task automatic ev(input int k);
		@(negedge sys_clk);
		src_attach_seen = (k == 0);
		sink_gone = (k == 1);
		goodcrc_sent = (k == 2);
		@(negedge sys_clk);
		{src_attach_seen, sink_gone, goodcrc_sent} = 3'b000;
	endtask

	// Bounded wait on one output bit; running out counts a mismatch and ends the run
	task automatic waitfor(input string nm, input int idx);
		int i;
		for (i = 0; i < 6 && outs[idx] !== 1'b1; i++)
			cyc(1);
		chk(nm, 10'h001, {9'h000, outs[idx]});
		if (outs[idx] !== 1'b1)
			print_verdict();
	endtask

	task automatic setup_cc(input logic d, input logic [1:0] c1, input logic [1:0] c2);
		role_dual = d;
		role_cc1 = c1;
		role_cc2 = c2;
		wr(8'h23, 8'h99);
	endtask

	initial
	begin
		do_reset();
		rd(8'h24, 8'h98, "capability");
		rd(8'h23, 8'h00, "command reset");
		rd(8'h30, 8'h00, "unmapped read");
		wr(8'h24, 8'h00);
		rd(8'h24, 8'h98, "capability after write");
		$display("test registers done");
		setup_cc(1'b0, 2'h1, 2'h1);
		cyc(2);
		chk("toggle without dual", 10'h000, {9'h000, outs[5]});
		setup_cc(1'b1, 2'h1, 2'h2);
		cyc(2);
		chk("toggle mixed fields", 10'h000, {9'h000, outs[5]});
		setup_cc(1'b1, 2'h2, 2'h2);
		chk("pull-down first", 10'h001, {9'h000, outs[3]});
		cyc(1);
		chk("toggle pull-down", 10'h001, {9'h000, outs[5]});
		do_reset();
		setup_cc(1'b1, 2'h1, 2'h1);
		chk("pull-up first", 10'h002, {8'h00, outs[4:3]});
		cyc(1);
		chk("toggle pull-up", 10'h001, {9'h000, outs[5]});
		$display("test search done");
		ev(0);
		cyc(2);
		ev(1);
		waitfor("unattached source", 2);
		chk("pull-up after loss", 10'h001, {9'h000, outs[4]});
		wr(8'h23, 8'h99);
		cyc(2);
		chk("search restarted", 10'h001, {9'h000, outs[5]});
		$display("test lost sink done");
		wr(8'h23, 8'hAA);
		cyc(1);
		chk("receiver armed", 10'h001, {9'h000, outs[1]});
		rd(8'h23, 8'hAA, "command readback");
		ev(2);
		waitfor("detect clear", 0);
		cyc(1);
		chk("detect clear pulse", 10'h000, {9'h000, outs[0]});
		$display("test receive stop done");
		wr(8'h23, 8'h33);
		chk("detect on", 10'h001, {9'h000, outs[6]});
		wr(8'h23, 8'h22);
		chk("detect off", 10'h000, {9'h000, outs[6]});
		wr(8'h23, 8'h66);
		chk("source off", 10'h000, {8'h00, outs[9:8]});
		wr(8'h23, 8'h44);
		chk("sink off", 10'h000, {9'h000, outs[7]});
		$display("test power commands done");
		wr(8'h23, 8'hAA);
		cyc(2);
		snap = outs;
		foreach (quiet_codes[k])
		begin
			wr(8'h23, quiet_codes[k]);
			cyc(2);
			chk("no action code", snap, outs);
		end
		$display("test quiet codes done");
		print_verdict();
	end
endmodule
